// ### ftuc_pkg.sv
// Package for the float-to-unsigned conversion slice: opcodes, status word layout,
// register offsets, reset values and the carrier structs.
// Assumes a 32-bit AXI4-Lite register bus and a 128-entry core register file.
package ftuc_pkg;

   localparam int NSLOT = 2;
   localparam int DATA_W = 32;
   localparam int FLAG_W = 6;
   localparam int DEST_W = 7;

   // Issue slots that carry the unit
   localparam logic [2:0] SLOT_NUM_A = 3'h1;
   localparam logic [2:0] SLOT_NUM_B = 3'h4;

   // Operation codes
   localparam logic [7:0] OP_CONV_ROUND = 8'h7b;
   localparam logic [7:0] OP_CONV_FLAGS = 8'h7c;
   localparam logic [7:0] OP_CONV_TRUNC = 8'h7d;

   // Exception flag bit positions, shared by the status word and the flags vector
   localparam int FLG_OVF_BIT = 0;
   localparam int FLG_INX_BIT = 1;
   localparam int FLG_UNF_BIT = 2;
   localparam int FLG_DBZ_BIT = 3;
   localparam int FLG_INV_BIT = 4;
   localparam int FLG_IFZ_BIT = 5;

   // Rounding modes
   localparam logic [1:0] RM_NEAREST = 2'h0;
   localparam logic [1:0] RM_ZERO = 2'h1;
   localparam logic [1:0] RM_POS_INF = 2'h2;
   localparam logic [1:0] RM_NEG_INF = 2'h3;

   // Status word fields
   localparam int PSW_RM_LSB = 8;
   localparam logic [31:0] PSW_WR_MASK = 32'h0000033f;
   localparam logic [31:0] PSW_RESET = 32'h00000000;

   // Register byte offsets
   localparam logic [3:0] OFS_PSW = 4'h0;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
   localparam int ADDR_W = 4;
   localparam logic [FLAG_W-1:0] IRQ_RESET = 6'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Single-precision fields
   localparam logic [7:0] EXP_SPECIAL = 8'hff;
   localparam logic [7:0] EXP_UNIT = 8'd150;
   localparam logic [7:0] EXP_TOO_BIG = 8'd159;
   localparam logic [5:0] SHIFT_CAP = 6'd33;
   localparam logic [31:0] UINT_MAX = 32'hffffffff;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [DATA_W-1:0] src;
      logic guard_en;
      logic [DATA_W-1:0] guard;
      logic [DEST_W-1:0] dest;
   } ftuc_issue_t;

   typedef struct packed {
      logic live;
      logic flags_only;
      logic [1:0] rmode;
      logic [DEST_W-1:0] dest;
      logic [DATA_W-1:0] src;
   } ftuc_s1_t;

   typedef struct packed {
      logic live;
      logic flags_only;
      logic [DEST_W-1:0] dest;
      logic [DATA_W-1:0] value;
      logic [FLAG_W-1:0] flags;
   } ftuc_s2_t;

   typedef struct packed {
      logic wr;
      logic [DEST_W-1:0] dest;
      logic [DATA_W-1:0] data;
   } ftuc_result_t;

endpackage : ftuc_pkg

// ### ftuc_convert.sv
// Combinational single-precision to unsigned 32-bit converter with exception flags.
// Assumes the caller supplies the rounding mode, forcing toward-zero for truncation.
`timescale 1ns/1ps
module ftuc_convert (
   input wire logic [31:0] src_in,
   input wire logic [1:0] rmode_in,
   output logic [31:0] value_out,
   output logic [5:0] flags_out
);
   logic sign;
   logic [7:0] expo;
   logic [22:0] frac;
   logic [23:0] sig;
   logic [7:0] rdiff;
   logic [5:0] shamt;
   logic [56:0] wide;
   logic [31:0] lval;
   logic [3:0] lsh;
   logic rbit;
   logic stk;
   logic inexact;
   logic inc;
   logic [31:0] mag;

   always_comb begin
      sign = src_in[31];
      expo = src_in[30:23];
      frac = src_in[22:0];
      sig = {1'b1, frac};
      rdiff = ftuc_pkg::EXP_UNIT - expo;
      shamt = (rdiff > 8'(ftuc_pkg::SHIFT_CAP)) ? ftuc_pkg::SHIFT_CAP : rdiff[5:0];
      wide = {sig, 33'h0} >> shamt;
      rbit = wide[32];
      stk = |wide[31:0];
      // Left shift reaches 8 for the top binade below 2^32
      lsh = 4'(expo - ftuc_pkg::EXP_UNIT);
      lval = {8'h00, sig} << lsh;
      inc = 1'b0;
      case (rmode_in)
         ftuc_pkg::RM_NEAREST: inc = rbit & (stk | wide[33]);
         ftuc_pkg::RM_POS_INF: inc = (rbit | stk) & ~sign;
         ftuc_pkg::RM_NEG_INF: inc = (rbit | stk) & sign;
         default: inc = 1'b0;
      endcase
      if (expo >= ftuc_pkg::EXP_UNIT) begin
         mag = lval;
         inexact = 1'b0;
      end else begin
         mag = {8'h00, wide[56:33]} + {31'h0, inc};
         inexact = rbit | stk;
      end
      value_out = 32'h0;
      flags_out = 6'h00;
      if (expo == 8'h00) begin
         // Denormals are flushed: convert zero instead
         flags_out[ftuc_pkg::FLG_IFZ_BIT] = (frac != 23'h0);
      end else if (expo == ftuc_pkg::EXP_SPECIAL && frac != 23'h0) begin
         flags_out[ftuc_pkg::FLG_INV_BIT] = 1'b1;
      end else if (expo >= ftuc_pkg::EXP_TOO_BIG) begin
         // Infinity and out-of-range magnitudes saturate or give zero
         value_out = sign ? 32'h0 : ftuc_pkg::UINT_MAX;
         flags_out[ftuc_pkg::FLG_INV_BIT] = 1'b1;
      end else if (sign) begin
         // Negatives rounding to a non-zero magnitude are out of range
         flags_out[ftuc_pkg::FLG_INV_BIT] = (mag != 32'h0);
         flags_out[ftuc_pkg::FLG_INX_BIT] = (mag == 32'h0) & inexact;
      end else begin
         value_out = mag;
         flags_out[ftuc_pkg::FLG_INX_BIT] = inexact;
      end
   end

endmodule : ftuc_convert

// ### ftuc_unit.sv
// Float-to-unsigned conversion slice of the floating-point ALU: two issue slots,
// three-cycle pipeline, sticky exception flags in the status word, AXI4-Lite registers.
// Assumes the issue logic presents one operation per slot per cycle, synchronous to mclk_in.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ftuc_unit (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input ftuc_pkg::ftuc_issue_t [ftuc_pkg::NSLOT-1:0] issue_in,
   output ftuc_pkg::ftuc_result_t [ftuc_pkg::NSLOT-1:0] result_out,
   input wire logic ext_flag_valid_in,
   input wire logic [ftuc_pkg::FLAG_W-1:0] ext_flags_in,
   output logic [31:0] processor_status_word_out,
   output logic irq_out,
   input wire logic [ftuc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [ftuc_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);

   ftuc_pkg::ftuc_s1_t [ftuc_pkg::NSLOT-1:0] s1_ff;
   ftuc_pkg::ftuc_s1_t [ftuc_pkg::NSLOT-1:0] nxt_s1;
   ftuc_pkg::ftuc_s2_t [ftuc_pkg::NSLOT-1:0] s2_ff;
   ftuc_pkg::ftuc_s2_t [ftuc_pkg::NSLOT-1:0] nxt_s2;
   ftuc_pkg::ftuc_result_t [ftuc_pkg::NSLOT-1:0] res_ff;
   ftuc_pkg::ftuc_result_t [ftuc_pkg::NSLOT-1:0] nxt_res;
   logic [ftuc_pkg::NSLOT-1:0][ftuc_pkg::FLAG_W-1:0] slot_set;
   logic [ftuc_pkg::FLAG_W-1:0] conv_set;
   logic [ftuc_pkg::FLAG_W-1:0] all_set;

   logic [31:0] psw_ff;
   logic [31:0] nxt_psw;
   logic [ftuc_pkg::FLAG_W-1:0] irq_stat_ff;
   logic [ftuc_pkg::FLAG_W-1:0] nxt_irq_stat;
   logic [ftuc_pkg::FLAG_W-1:0] irq_mask_ff;
   logic [ftuc_pkg::FLAG_W-1:0] nxt_irq_mask;

   logic aw_ff;
   logic nxt_aw;
   logic [ftuc_pkg::ADDR_W-1:0] awaddr_ff;
   logic [ftuc_pkg::ADDR_W-1:0] nxt_awaddr;
   logic w_ff;
   logic nxt_w;
   logic [31:0] wdata_ff;
   logic [31:0] nxt_wdata;
   logic [3:0] wstrb_ff;
   logic [3:0] nxt_wstrb;
   logic bvalid_ff;
   logic nxt_bvalid;
   logic [1:0] bresp_ff;
   logic [1:0] nxt_bresp;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] rresp_ff;
   logic [1:0] nxt_rresp;
   logic wr_fire;
   logic [31:0] wmask;
   logic [31:0] wval;

   // Per-slot three-stage pipeline: issue capture, convert, retire
   genvar g;
   generate
      for (g = 0; g < ftuc_pkg::NSLOT; g++) begin : g_slot
         logic [31:0] conv_value;
         logic [ftuc_pkg::FLAG_W-1:0] conv_flags;
         logic known_op;

         ftuc_convert u_convert (
            .src_in(s1_ff[g].src),
            .rmode_in(s1_ff[g].rmode),
            .value_out(conv_value),
            .flags_out(conv_flags)
         );

         always_comb begin
            known_op = (issue_in[g].opcode == ftuc_pkg::OP_CONV_ROUND) ||
                       (issue_in[g].opcode == ftuc_pkg::OP_CONV_FLAGS) ||
                       (issue_in[g].opcode == ftuc_pkg::OP_CONV_TRUNC);
            nxt_s1[g].live = issue_in[g].valid & known_op &
                             (~issue_in[g].guard_en | issue_in[g].guard[0]);
            nxt_s1[g].flags_only = (issue_in[g].opcode == ftuc_pkg::OP_CONV_FLAGS);
            if (issue_in[g].opcode == ftuc_pkg::OP_CONV_TRUNC) begin
               nxt_s1[g].rmode = ftuc_pkg::RM_ZERO;
            end else begin
               nxt_s1[g].rmode = psw_ff[ftuc_pkg::PSW_RM_LSB +: 2];
            end
            nxt_s1[g].dest = issue_in[g].dest;
            nxt_s1[g].src = issue_in[g].src;

            nxt_s2[g].live = s1_ff[g].live;
            nxt_s2[g].flags_only = s1_ff[g].flags_only;
            nxt_s2[g].dest = s1_ff[g].dest;
            nxt_s2[g].value = conv_value;
            nxt_s2[g].flags = conv_flags;

            nxt_res[g].wr = s2_ff[g].live;
            nxt_res[g].dest = s2_ff[g].dest;
            if (s2_ff[g].flags_only) begin
               nxt_res[g].data = {26'h0, s2_ff[g].flags};
            end else begin
               nxt_res[g].data = s2_ff[g].value;
            end
            // Flags-only operations report but never touch the status word
            if (s2_ff[g].live && !s2_ff[g].flags_only) begin
               slot_set[g] = s2_ff[g].flags;
            end else begin
               slot_set[g] = '0;
            end
         end

         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               s1_ff[g] <= '0;
               s2_ff[g] <= '0;
               res_ff[g] <= '0;
            end else begin
               s1_ff[g] <= nxt_s1[g];
               s2_ff[g] <= nxt_s2[g];
               res_ff[g] <= nxt_res[g];
            end
         end
      end
   endgenerate

   assign result_out = res_ff;

   // Status word, interrupt status and mask
   always_comb begin
      conv_set = '0;
      for (int i = 0; i < ftuc_pkg::NSLOT; i++) begin
         conv_set = conv_set | slot_set[i];
      end
      all_set = conv_set | (ext_flag_valid_in ? ext_flags_in : '0);
      wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
      wval = wdata_ff & wmask;
      nxt_psw = psw_ff;
      nxt_irq_stat = irq_stat_ff;
      nxt_irq_mask = irq_mask_ff;
      if (wr_fire && awaddr_ff == ftuc_pkg::OFS_PSW) begin
         // Explicit status word write is the only way to clear flags
         nxt_psw = ((psw_ff & ~wmask) | wval) & ftuc_pkg::PSW_WR_MASK;
      end
      if (wr_fire && awaddr_ff == ftuc_pkg::OFS_IRQ_STATUS) begin
         nxt_irq_stat = irq_stat_ff & ~wval[ftuc_pkg::FLAG_W-1:0];
      end
      if (wr_fire && awaddr_ff == ftuc_pkg::OFS_IRQ_MASK) begin
         nxt_irq_mask = (irq_mask_ff & ~wmask[ftuc_pkg::FLAG_W-1:0]) |
                        wval[ftuc_pkg::FLAG_W-1:0];
      end
      // Sets land with the destination write and win over a clear
      nxt_psw[ftuc_pkg::FLAG_W-1:0] = nxt_psw[ftuc_pkg::FLAG_W-1:0] | all_set;
      nxt_irq_stat = nxt_irq_stat | conv_set;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         psw_ff <= ftuc_pkg::PSW_RESET;
         irq_stat_ff <= ftuc_pkg::IRQ_RESET;
         irq_mask_ff <= ftuc_pkg::IRQ_RESET;
      end else begin
         psw_ff <= nxt_psw;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
      end
   end

   assign processor_status_word_out = psw_ff;
   assign irq_out = |(irq_stat_ff & irq_mask_ff);

   // AXI4-Lite slave: address and data captured in either order, then written
   assign s_axi_awready_out = ~aw_ff & ~bvalid_ff;
   assign s_axi_wready_out = ~w_ff & ~bvalid_ff;
   assign s_axi_arready_out = ~rvalid_ff;
   assign wr_fire = aw_ff & w_ff & ~bvalid_ff;

   always_comb begin
      nxt_aw = aw_ff;
      nxt_awaddr = awaddr_ff;
      nxt_w = w_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         nxt_aw = 1'b1;
         nxt_awaddr = {s_axi_awaddr_in[ftuc_pkg::ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         nxt_w = 1'b1;
         nxt_wdata = s_axi_wdata_in;
         nxt_wstrb = s_axi_wstrb_in;
      end
      if (wr_fire) begin
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_bvalid = 1'b1;
         case (awaddr_ff)
            ftuc_pkg::OFS_PSW, ftuc_pkg::OFS_IRQ_STATUS, ftuc_pkg::OFS_IRQ_MASK: begin
               nxt_bresp = ftuc_pkg::RESP_OKAY;
            end
            default: nxt_bresp = ftuc_pkg::RESP_SLVERR;
         endcase
      end else if (bvalid_ff && s_axi_bready_in) begin
         nxt_bvalid = 1'b0;
      end
   end

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = ftuc_pkg::RESP_OKAY;
         case ({s_axi_araddr_in[ftuc_pkg::ADDR_W-1:2], 2'h0})
            ftuc_pkg::OFS_PSW: nxt_rdata = psw_ff;
            ftuc_pkg::OFS_IRQ_STATUS: nxt_rdata = {26'h0, irq_stat_ff};
            ftuc_pkg::OFS_IRQ_MASK: nxt_rdata = {26'h0, irq_mask_ff};
            default: begin
               nxt_rdata = 32'h0;
               nxt_rresp = ftuc_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready_in) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_ff <= 1'b0;
         awaddr_ff <= '0;
         w_ff <= 1'b0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= ftuc_pkg::RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= ftuc_pkg::RESP_OKAY;
      end else begin
         aw_ff <= nxt_aw;
         awaddr_ff <= nxt_awaddr;
         w_ff <= nxt_w;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;

endmodule : ftuc_unit

// ### ftuc_unit_asserts.sv
// Checker for ftuc_unit: latency, guard, saturation, sticky flags and bus answers.
// Assumes the single clock mclk_in and the active-low reset rst_n_in.
`timescale 1ns/1ps
module ftuc_unit_asserts (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input ftuc_pkg::ftuc_issue_t [ftuc_pkg::NSLOT-1:0] issue_in,
   input ftuc_pkg::ftuc_result_t [ftuc_pkg::NSLOT-1:0] result_out,
   input wire logic ext_flag_valid_in,
   input wire logic [ftuc_pkg::FLAG_W-1:0] ext_flags_in,
   input wire logic [31:0] processor_status_word_out,
   input wire logic irq_out,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   logic [1:0] take;
   logic [1:0] skip;
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         skip[s] = issue_in[s].valid && issue_in[s].guard_en && !issue_in[s].guard[0];
         take[s] = issue_in[s].valid && !skip[s] && (issue_in[s].opcode inside
            {ftuc_pkg::OP_CONV_ROUND, ftuc_pkg::OP_CONV_FLAGS, ftuc_pkg::OP_CONV_TRUNC});
      end
   end
   sequence s_inf_in;
      take[0] && issue_in[0].opcode != ftuc_pkg::OP_CONV_FLAGS && issue_in[0].src == 32'h7f800000;
   endsequence
   sequence s_sat_out;
      result_out[0].wr && result_out[0].data == ftuc_pkg::UINT_MAX
         && processor_status_word_out[ftuc_pkg::FLG_INV_BIT];
   endsequence
   a_latency_slot0: assert property (take[0] |-> ##3 result_out[0].wr)
      else $error("slot 0 result not written three cycles after issue");
   a_latency_slot1: assert property (take[1] |-> ##3 result_out[1].wr)
      else $error("slot 1 result not written three cycles after issue");
   a_guard_off: assert property (skip[0] |-> ##3 !result_out[0].wr)
      else $error("guarded-off operation wrote a result");
   a_flags_vector: assert property (take[0]
      && issue_in[0].opcode == ftuc_pkg::OP_CONV_FLAGS
      |-> ##3 result_out[0].data[31:6] == 26'h0)
      else $error("flags-only result has bits above the flag field");
   a_inf_saturate: assert property (s_inf_in |-> ##3 s_sat_out)
      else $error("infinity did not saturate with invalid set");
   a_flags_sticky: assert property (
      |($past(processor_status_word_out) & ~processor_status_word_out & 32'h3f)
      |-> $rose(s_axi_bvalid_out))
      else $error("status flag cleared without a register write");
   a_ext_or: assert property (ext_flag_valid_in
      |=> (processor_status_word_out[5:0] & $past(ext_flags_in)) == $past(ext_flags_in))
      else $error("simultaneous flag update lost");
   a_irq_cause: assert property ($rose(irq_out)
      |-> result_out[0].wr || result_out[1].wr || $rose(s_axi_bvalid_out))
      else $error("interrupt rose without retire or register write");
   a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write answer late");
   a_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted while answer pending");
endmodule : ftuc_unit_asserts

bind ftuc_unit ftuc_unit_asserts u_asserts (.mclk_in, .rst_n_in, .issue_in, .result_out,
   .ext_flag_valid_in, .ext_flags_in, .processor_status_word_out, .irq_out, .s_axi_awvalid_in,
   .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
   .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out);

// ### ftuc_regfile_model.sv
// Register-file side of the core: records every result write of both issue slots.
// Assumes result_in comes straight from the conversion slice on mclk_in.
`timescale 1ns/1ps
module ftuc_regfile_model (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input ftuc_pkg::ftuc_result_t [ftuc_pkg::NSLOT-1:0] result_in
);
   logic [31:0] rf [128];
   int n_wr;
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         n_wr <= 0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (result_in[s].wr === 1'b1) begin
               rf[result_in[s].dest] <= result_in[s].data;
            end
         end
         n_wr <= n_wr + int'(result_in[0].wr === 1'b1) + int'(result_in[1].wr === 1'b1);
      end
   end
endmodule : ftuc_regfile_model

// ### ftuc_unit_tb_top.sv
// Self-checking bench for ftuc_unit: issue slots, status flags, interrupt and registers.
// Assumes a 50 MHz clock and the register-file model beside the design.
`timescale 1ns/1ps
module ftuc_unit_tb_top;
   localparam logic [7:0] RND = ftuc_pkg::OP_CONV_ROUND;
   localparam logic [7:0] FLG = ftuc_pkg::OP_CONV_FLAGS;
   localparam logic [7:0] TRZ = ftuc_pkg::OP_CONV_TRUNC;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   ftuc_pkg::ftuc_issue_t [1:0] issue_in = '0;
   ftuc_pkg::ftuc_result_t [1:0] result_out;
   logic ext_flag_valid_in = 1'b0;
   logic [5:0] ext_flags_in = 6'h00;
   logic [31:0] processor_status_word_out;
   logic irq_out;
   logic [3:0] s_axi_awaddr_in = 4'h0;
   logic [3:0] s_axi_araddr_in = 4'h0;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic [31:0] s_axi_rdata_out;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   ftuc_unit dut (.mclk_in, .rst_n_in, .issue_in, .result_out, .ext_flag_valid_in, .ext_flags_in,
      .processor_status_word_out, .irq_out, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
      .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
   ftuc_regfile_model u_rf (.mclk_in, .rst_n_in, .result_in(result_out));
   initial begin
      forever #10 mclk_in = ~mclk_in;
   end
   task automatic finish_test();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] rs;
      @(posedge mclk_in);
      s_axi_awaddr_in <= a;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wdata_in <= d;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         aw = s_axi_awvalid_in && s_axi_awready_out;
         w = s_axi_wvalid_in && s_axi_wready_out;
         b = s_axi_bvalid_out;
         rs = s_axi_bresp_out;
         @(posedge mclk_in);
         if (aw) s_axi_awvalid_in <= 1'b0;
         if (w) s_axi_wvalid_in <= 1'b0;
      end while (!b);
      s_axi_bready_in <= 1'b0;
      chk(rs, er);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ar, r;
      logic [31:0] d;
      logic [1:0] rs;
      @(posedge mclk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do begin
         @(negedge mclk_in);
         ar = s_axi_arvalid_in && s_axi_arready_out;
         r = s_axi_rvalid_out;
         d = s_axi_rdata_out;
         rs = s_axi_rresp_out;
         @(posedge mclk_in);
         if (ar) s_axi_arvalid_in <= 1'b0;
      end while (!r);
      s_axi_rready_in <= 1'b0;
      chk(d, e);
      chk(rs, er);
   endtask : rd
   // Guard code: bit 1 enables the guard, bit 0 is its lsb; upper guard bits are all ones
   task automatic put(input int s, input logic [7:0] op, input logic [31:0] src,
         input logic [1:0] g);
      issue_in[s].valid <= 1'b1;
      issue_in[s].opcode <= op;
      issue_in[s].src <= src;
      issue_in[s].guard_en <= g[1];
      issue_in[s].guard <= {31'h7fffffff, g[0]};
      issue_in[s].dest <= 7'(16 + s);
   endtask : put
   task automatic fire(input logic [5:0] ext);
      @(posedge mclk_in);
      issue_in[0].valid <= 1'b0;
      issue_in[1].valid <= 1'b0;
      @(posedge mclk_in);
      ext_flag_valid_in <= |ext;
      ext_flags_in <= ext;
      @(posedge mclk_in);
      ext_flag_valid_in <= 1'b0;
      #1;
   endtask : fire
   task automatic conv(input logic [7:0] op, input logic [31:0] src, input logic [1:0] g,
         input logic [31:0] e);
      @(posedge mclk_in);
      put(0, op, src, g);
      fire(6'h00);
      chk(result_out[0].wr, g != 2'h2);
      if (g != 2'h2) chk(result_out[0].data, e);
   endtask : conv
   task automatic t_regs();
      rd(4'h0, 32'h0, 2'h0);
      rd(4'h8, 32'h0, 2'h0);
      wr(4'hc, 32'h1, 2'h2);
      rd(4'hc, 32'h0, 2'h2);
      wr(4'h0, 32'hffffffff, 2'h0);
      rd(4'h0, 32'h0000033f, 2'h0);
   endtask : t_regs
   task automatic t_table();
      logic [31:0] src [10] = '{32'h40400000, 32'h40247ae1, 32'hff4fffff, 32'h7f800000,
         32'hbfc147ae, 32'h00400000, 32'h7fffffff, 32'hffbfffff, 32'h4f800000, 32'h4f7fffff};
      logic [31:0] e [10] = '{32'h3, 32'h3, 32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0,
         32'hffffffff, 32'hffffff00};
      logic [5:0] f [10] = '{6'h00, 6'h02, 6'h10, 6'h10, 6'h10, 6'h20, 6'h10, 6'h10, 6'h10,
         6'h00};
      for (int i = 0; i < 10; i++) begin
         wr(4'h0, 32'h0, 2'h0);
         conv(RND, src[i], 2'h1, e[i]);
         chk(processor_status_word_out[5:0], f[i]);
         conv(TRZ, src[i], 2'h3, (i == 1) ? 32'h2 : e[i]);
         wr(4'h0, 32'h0, 2'h0);
         conv(FLG, src[i], 2'h0, {26'h0, f[i]});
         chk(processor_status_word_out[5:0], 6'h00);
      end
   endtask : t_table
   task automatic t_modes();
      logic [31:0] e [4] = '{32'h2, 32'h2, 32'h3, 32'h2};
      logic [31:0] f [4] = '{32'h02, 32'h02, 32'h02, 32'h10};
      for (int m = 0; m < 4; m++) begin
         wr(4'h0, {22'h0, 2'(m), 8'h00}, 2'h0);
         conv(RND, 32'h40200000, 2'h1, e[m]);
         conv(TRZ, 32'h40200000, 2'h1, 32'h2);
         conv(FLG, 32'hbe99999a, 2'h1, f[m]);
      end
   endtask : t_modes
   task automatic t_guard();
      int n;
      wr(4'h0, 32'h0, 2'h0);
      n = u_rf.n_wr;
      conv(RND, 32'h7f800000, 2'h2, 32'h0);
      chk(processor_status_word_out[5:0], 6'h00);
      @(posedge mclk_in);
      #1;
      chk(u_rf.n_wr, n);
   endtask : t_guard
   task automatic t_or();
      @(posedge mclk_in);
      put(0, RND, 32'h40247ae1, 2'h3);
      put(1, TRZ, 32'h7f800000, 2'h1);
      fire(6'h01);
      chk(result_out[1].wr, 1'b1);
      chk(result_out[1].data, 32'hffffffff);
      chk(processor_status_word_out[5:0], 6'h13);
      conv(RND, 32'h40400000, 2'h1, 32'h3);
      chk(processor_status_word_out[5:0], 6'h13);
      chk(u_rf.rf[17], 32'hffffffff);
      wr(4'h0, 32'h0, 2'h0);
      chk(processor_status_word_out[5:0], 6'h00);
   endtask : t_or
   task automatic t_irq();
      wr(4'h4, 32'h3f, 2'h0);
      rd(4'h4, 32'h0, 2'h0);
      wr(4'h8, 32'h10, 2'h0);
      chk(irq_out, 1'b0);
      conv(TRZ, 32'hbfc147ae, 2'h1, 32'h0);
      chk(irq_out, 1'b1);
      rd(4'h4, 32'h10, 2'h0);
      wr(4'h8, 32'h0, 2'h0);
      chk(irq_out, 1'b0);
      wr(4'h8, 32'h10, 2'h0);
      chk(irq_out, 1'b1);
      wr(4'h4, 32'h10, 2'h0);
      chk(irq_out, 1'b0);
   endtask : t_irq
   initial begin
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_regs();
      t_table();
      t_modes();
      t_guard();
      t_or();
      t_irq();
      finish_test();
   end
endmodule : ftuc_unit_tb_top
